/* File: rtl/msc_start_select.sv */
// Start-path selector for a sensorless three-phase motor driver.
// Assumes position sensing, align, accelerate and brake engines
// outside that report completion; registers on a plain port.
//
// Contract
// - Code is mantissa shifted by exponent, times 0.92
// - Code zero is zero; one is smallest
// - Motor is still, forward or reverse
// - Still motor: initialise commutation before driving
// - Position sensing uses winding inductance variation
// - Align pulls rotor to fixed phase pattern
// - Forward and fast: resynchronise into closed loop
// - Reverse drive decelerates through zero, accelerates
// - Otherwise wait for stop or brake
// - Stopped reverse motor starts as still one
// - UW lagging UV by 60 is forward
// - Brake only with nonzero brake duration
// - Nonzero current threshold selects position sensing
// - Too fast reverse: coast and detect again
`timescale 1ns/100ps
module msc_start_select #(
	parameter int STILL_BASE_CYC = msc_pkg::MSC_STILL_BASE_CYC,
	parameter int RVS_BASE_CYC = msc_pkg::MSC_RVS_BASE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [msc_pkg::MSC_AW-1:0] regAddr,
	input wire logic [msc_pkg::MSC_DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [msc_pkg::MSC_DW-1:0] regRdData_q,
	input wire logic restart,
	input wire logic cmpUv,
	input wire logic cmpUw,
	input wire logic senseDone,
	input wire logic alignDone,
	input wire logic zeroSpeed,
	input wire logic handoffReached,
	input wire logic brakeCurrentLow,
	output msc_pkg::msc_path_e path_q,
	output msc_pkg::msc_cond_e motorCond_q,
	output logic coast_q,
	output logic posSense_q,
	output logic alignDrive_q,
	output logic lowSideBrake_q,
	output logic reverseDrive_q,
	output logic accelDrive_q,
	output logic closedLoop_q,
	output logic [msc_pkg::MSC_KT_W-1:0] bemfConstant_q
);
	import msc_pkg::*;
	// ------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------
	logic [11:0] cfg_q; // Start options
	logic [5:0] thr_q; // Still timeout and reverse limit codes
	logic [6:0] bemfCode_q; // Back-EMF constant code
	wire wrCfg = regWr && regAddr == MSC_REG_CFG;
	wire wrThr = regWr && regAddr == MSC_REG_THR;
	wire wrBemf = regWr && regAddr == MSC_REG_BEMF;
	wire wrGo = regWr && regAddr == MSC_REG_CTRL
		&& regWrData[MSC_CTRL_GO_BIT];
	// Option fields
	wire isdEnable = cfg_q[MSC_CFG_ISD_BIT];
	wire reverse_drive_enable = cfg_q[MSC_CFG_RVS_BIT];
	wire resyncEnable = cfg_q[MSC_CFG_SYNC_BIT];
	wire [2:0] brake_duration = cfg_q[MSC_CFG_BRK_LSB +: 3];
	wire [3:0] position_sense_current_threshold =
		cfg_q[MSC_CFG_POS_LSB +: 4];
	wire [1:0] stillCode = thr_q[MSC_THR_STILL_LSB +: 2];
	wire [1:0] reverse_drive_speed_limit = thr_q[MSC_THR_RVS_LSB +: 2];
	// Brake and position sensing gated by nonzero fields
	wire brakeOn = brake_duration != 3'b000;
	wire posSenseOn = position_sense_current_threshold != 4'b0000;
	// ------------------------------------------------------------
	// Derived counts
	// ------------------------------------------------------------
	wire [MSC_CNT_W-1:0] stillCycles =
		MSC_CNT_W'(STILL_BASE_CYC) << stillCode;
	wire [MSC_CNT_W-1:0] rvsLimitCycles =
		MSC_CNT_W'(RVS_BASE_CYC) << reverse_drive_speed_limit;
	wire [15:0] brakeCycles =
		16'(brake_duration * MSC_BRK_STEP_CYC);
	// ------------------------------------------------------------
	// Rotor watch and back-EMF decode
	// ------------------------------------------------------------
	logic watchClear_q; // Arms one measurement
	logic watchDone;
	msc_cond_e watchCond;
	logic [MSC_CNT_W-1:0] watchPeriod;
	msc_rotor_watch #(
		.CW(MSC_CNT_W)
	) uWatch (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clear(watchClear_q),
		.cmpUv(cmpUv),
		.cmpUw(cmpUw),
		.stillCycles(stillCycles),
		.done_q(watchDone),
		.cond_q(watchCond),
		.period_q(watchPeriod)
	);
	msc_bemf_decode uBemf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.code(bemfCode_q),
		.bemfConstant_q(bemfConstant_q)
	);
	// ------------------------------------------------------------
	// Path judgement
	// ------------------------------------------------------------
	// Shorter period means faster rotation
	wire rvsTooFast = watchPeriod < rvsLimitCycles;
	// Stationary entry: brake first if enabled, then initialise
	wire [3:0] initPath = posSenseOn ? MSC_POS_SENSE
		: MSC_ALIGN;
	wire [3:0] stillPath = brakeOn ? MSC_BRAKE : initPath;
	// Forward without resync is handled like a still start
	wire [3:0] fwdPath = resyncEnable ? MSC_CLOSED : stillPath;
	// Reverse: coast if fast, else drive through zero, else brake, else wait
	wire [3:0] rvsPath = rvsTooFast ? MSC_DETECT
		: reverse_drive_enable ? MSC_RVS_DRIVE
		: brakeOn ? MSC_BRAKE : MSC_DETECT;
	wire [3:0] judgedPath = watchCond == MSC_FWD ? fwdPath
		: watchCond == MSC_RVS ? rvsPath : stillPath;
	// ------------------------------------------------------------
	// Brake timer: current must stay low for the whole duration
	// ------------------------------------------------------------
	logic [15:0] brkCnt_q;
	wire brakeDone = brakeCurrentLow && brkCnt_q >= brakeCycles;
	// ------------------------------------------------------------
	// Next path
	// ------------------------------------------------------------
	msc_path_e path_d;
	wire startReq = restart || wrGo;
	always_comb begin
		path_d = path_q;
		case (path_q)
			MSC_POWERON: begin
				// Without detection the motor counts as still
				path_d = isdEnable ? MSC_DETECT
					: msc_path_e'(stillPath);
			end
			MSC_DETECT: begin
				if (watchDone) begin
					path_d = msc_path_e'(judgedPath);
				end
			end
			MSC_BRAKE: begin
				// Stopped motor continues as a still one
				if (brakeDone) begin
					path_d = msc_path_e'(initPath);
				end
			end
			MSC_POS_SENSE: begin
				if (senseDone) begin
					path_d = MSC_ACCEL;
				end
			end
			MSC_ALIGN: begin
				if (alignDone) begin
					path_d = MSC_ACCEL;
				end
			end
			MSC_RVS_DRIVE: begin
				// Keep pushing forward through zero speed
				if (zeroSpeed) begin
					path_d = MSC_ACCEL;
				end
			end
			MSC_ACCEL: begin
				if (handoffReached) begin
					path_d = MSC_CLOSED;
				end
			end
			MSC_CLOSED: begin
				path_d = MSC_CLOSED;
			end
			default: begin
				path_d = MSC_POWERON;
			end
		endcase
		// A restart abandons any committed path
		if (startReq) begin
			path_d = MSC_POWERON;
		end
	end
	// ------------------------------------------------------------
	// Path, condition and drive outputs
	// ------------------------------------------------------------
	// Drive outputs follow the next path so they align with path_q
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			path_q <= MSC_POWERON;
			coast_q <= 1'b1;
			posSense_q <= 1'b0;
			alignDrive_q <= 1'b0;
			lowSideBrake_q <= 1'b0;
			reverseDrive_q <= 1'b0;
			accelDrive_q <= 1'b0;
			closedLoop_q <= 1'b0;
		end else begin
			path_q <= path_d;
			coast_q <= path_d == MSC_POWERON || path_d == MSC_DETECT;
			posSense_q <= path_d == MSC_POS_SENSE;
			alignDrive_q <= path_d == MSC_ALIGN;
			lowSideBrake_q <= path_d == MSC_BRAKE;
			reverseDrive_q <= path_d == MSC_RVS_DRIVE;
			accelDrive_q <= path_d == MSC_ACCEL;
			closedLoop_q <= path_d == MSC_CLOSED;
		end
	end
	// Condition is recorded at every detection result, set still at a start without detection, and held otherwise
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			motorCond_q <= MSC_STILL;
		end else if (path_q == MSC_POWERON && !isdEnable) begin
			motorCond_q <= MSC_STILL;
		end else if (path_q == MSC_DETECT && watchDone) begin
			motorCond_q <= watchCond;
		end
	end
	// Arm the watch on every entry into detection
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			watchClear_q <= 1'b0;
		end else begin
			watchClear_q <= path_d == MSC_DETECT &&
				(path_q != MSC_DETECT || watchDone);
		end
	end
	// Brake timer restarts whenever current rises again
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			brkCnt_q <= '0;
		end else if (path_q != MSC_BRAKE || !brakeCurrentLow) begin
			brkCnt_q <= '0;
		end else if (!brakeDone) begin
			brkCnt_q <= brkCnt_q + 1'b1;
		end
	end
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Settings are the configurer's duty to keep current safe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= MSC_CFG_RST;
			thr_q <= MSC_THR_RST;
			bemfCode_q <= MSC_BEMF_RST;
		end else begin
			if (wrCfg) begin
				cfg_q <= regWrData[11:0];
			end
			if (wrThr) begin
				thr_q <= regWrData[5:0];
			end
			if (wrBemf) begin
				bemfCode_q <= regWrData[6:0];
			end
		end
	end
	// Read mux; unmapped and write-only offsets read zero
	wire [MSC_DW-1:0] statWord = MSC_DW'({motorCond_q, path_q});
	wire [MSC_DW-1:0] rdMux =
		regAddr == MSC_REG_CFG ? MSC_DW'(cfg_q)
		: regAddr == MSC_REG_THR ? MSC_DW'(thr_q)
		: regAddr == MSC_REG_BEMF ? MSC_DW'(bemfCode_q)
		: regAddr == MSC_REG_STAT ? statWord
		: regAddr == MSC_REG_KVAL ? MSC_DW'(bemfConstant_q)
		: '0;
	// Data only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			regRdData_q <= '0;
		end else begin
			regRdData_q <= regRd ? rdMux : '0;
		end
	end
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence stillSeen;
		path_q == MSC_DETECT && watchDone && watchCond == MSC_STILL
		&& !startReq;
	endsequence
	sequence fwdFast;
		path_q == MSC_DETECT && watchDone && watchCond == MSC_FWD
		&& resyncEnable && !startReq;
	endsequence
	still_init_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stillSeen and !brakeOn |=> path_q == (posSenseOn
		? MSC_POS_SENSE : MSC_ALIGN) && motorCond_q == MSC_STILL)
		else $error("still motor not sent to initialisation");
	resync_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fwdFast |=> path_q == MSC_CLOSED && closedLoop_q)
		else $error("forward motor not resynchronised");
	brake_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!brakeOn && path_q != MSC_BRAKE |=> !lowSideBrake_q)
		else $error("brake entered with zero duration");
	rvs_coast_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		path_q == MSC_DETECT && watchDone && watchCond == MSC_RVS
		&& rvsTooFast && !startReq
		|=> path_q == MSC_DETECT && coast_q && watchClear_q)
		else $error("fast reverse motor was driven");
	rvs_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reverseDrive_q && zeroSpeed && !startReq
		|=> accelDrive_q && !reverseDrive_q)
		else $error("reverse drive did not continue forward");
	restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		startReq |=> path_q == MSC_POWERON && coast_q)
		else $error("restart did not return to power-on");
	align_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(alignDrive_q) |-> !$past(posSenseOn))
		else $error("align chosen while position sensing enabled");
	read_late_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		regRd && regAddr == MSC_REG_BEMF |=> regRdData_q
		== MSC_DW'($past(bemfCode_q)) ##1 ($past(regRd)
		|| regRdData_q == '0))
		else $error("read data not in the following cycle");
endmodule

/* File: rtl/msc_pkg.sv */
// Shared constants and types for the motor start-path selector.
// Assumes a single 250 MHz core clock and a plain register port.
package msc_pkg;
	// ------------------------------------------------------------
	// Register port shape
	// ------------------------------------------------------------
	localparam int MSC_AW = 4;
	localparam int MSC_DW = 32;
	localparam logic [3:0] MSC_REG_CFG = 4'h0; // Start options
	localparam logic [3:0] MSC_REG_THR = 4'h1; // Speed limits
	localparam logic [3:0] MSC_REG_BEMF = 4'h2; // Back-EMF code
	localparam logic [3:0] MSC_REG_CTRL = 4'h3; // Restart command
	localparam logic [3:0] MSC_REG_STAT = 4'h4; // Path and condition
	localparam logic [3:0] MSC_REG_KVAL = 4'h5; // Decoded constant
	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int MSC_CFG_ISD_BIT = 0;
	localparam int MSC_CFG_RVS_BIT = 1;
	localparam int MSC_CFG_SYNC_BIT = 2;
	localparam int MSC_CFG_BRK_LSB = 4;
	localparam int MSC_CFG_POS_LSB = 8;
	localparam int MSC_THR_STILL_LSB = 0;
	localparam int MSC_THR_RVS_LSB = 4;
	localparam int MSC_CTRL_GO_BIT = 0;
	localparam int MSC_STAT_COND_LSB = 4;
	localparam logic [11:0] MSC_CFG_RST = 12'h005;
	localparam logic [5:0] MSC_THR_RST = 6'h00;
	localparam logic [6:0] MSC_BEMF_RST = 7'h00;
	// ------------------------------------------------------------
	// Back-EMF code layout; scale in hundredths of a mV/Hz
	// ------------------------------------------------------------
	localparam int MSC_KT_EXP_W = 3;
	localparam int MSC_KT_MAN_W = 4;
	localparam int MSC_KT_W = 18;
	localparam logic [6:0] MSC_KT_STEP_CENTI = 7'd92;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int MSC_CLK_MHZ = 250;
	localparam int MSC_BRK_STEP_US = 10;
	localparam int MSC_BRK_STEP_CYC = MSC_BRK_STEP_US * MSC_CLK_MHZ;
	localparam int MSC_STILL_BASE_US = 100;
	localparam int MSC_STILL_BASE_CYC = MSC_STILL_BASE_US * MSC_CLK_MHZ;
	localparam int MSC_RVS_BASE_US = 50;
	localparam int MSC_RVS_BASE_CYC = MSC_RVS_BASE_US * MSC_CLK_MHZ;
	localparam int MSC_CNT_W = 24;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		MSC_POWERON, MSC_DETECT, MSC_BRAKE, MSC_POS_SENSE,
		MSC_ALIGN, MSC_RVS_DRIVE, MSC_ACCEL, MSC_CLOSED
	} msc_path_e;
	typedef enum logic [1:0] {
		MSC_STILL, MSC_FWD, MSC_RVS
	} msc_cond_e;
endpackage

/* File: rtl/msc_bemf_decode.sv */
// Decodes the 7-bit back-EMF constant code into a scaled value.
// Assumes the code is held stable in a register by its owner.
`timescale 1ns/100ps
module msc_bemf_decode (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [6:0] code,
	output logic [msc_pkg::MSC_KT_W-1:0] bemfConstant_q
);
	import msc_pkg::*;
	// Exponent sits above the mantissa in the code
	wire [MSC_KT_EXP_W-1:0] expo = code[6:4];
	wire [MSC_KT_MAN_W-1:0] mant = code[3:0];
	// Mantissa shifted by exponent, at most 1920
	wire [10:0] digital = 11'({7'h00, mant} << expo);
	// Scaled by the step; all-zero code gives zero naturally
	wire [MSC_KT_W-1:0] scaled =
		MSC_KT_W'(digital) * MSC_KT_W'(MSC_KT_STEP_CENTI);
	// ------------------------------------------------------------
	// Output register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bemfConstant_q <= '0;
		end else begin
			bemfConstant_q <= scaled;
		end
	end
	kt_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		code == 7'h7F |=> bemfConstant_q == 18'd176640)
		else $error("top code does not decode to full scale");
	kt_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		code == 7'h00 ##1 code == 7'h01 |-> bemfConstant_q == 18'd0
		##1 bemfConstant_q == 18'd92)
		else $error("zero or smallest code decoded wrong");
endmodule

/* File: rtl/msc_rotor_watch.sv */
// Watches two phase comparators of a coasting motor and reports
// condition and electrical period. Comparators are synchronous.
`timescale 1ns/100ps
module msc_rotor_watch #(
	parameter int CW = 24
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic cmpUv,
	input wire logic cmpUw,
	input wire logic [CW-1:0] stillCycles,
	output logic done_q,
	output msc_pkg::msc_cond_e cond_q,
	output logic [CW-1:0] period_q
);
	import msc_pkg::*;
	logic uvPrev_q; // Last comparator sample for edge finding
	logic seen_q; // First rising edge already found
	logic armed_q; // Measurement running
	logic [CW-1:0] cnt_q; // Cycles since last edge
	wire uvRise = cmpUv & ~uvPrev_q;
	wire quiet = cnt_q >= stillCycles;
	// Forward when UW is still low at a UV rise: UW lags by 60 deg
	wire fwdSeen = ~cmpUw;
	// ------------------------------------------------------------
	// Measurement
	// ------------------------------------------------------------
	// One report per arming; the owner re-arms with clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			uvPrev_q <= 1'b0;
			seen_q <= 1'b0;
			armed_q <= 1'b0;
			cnt_q <= '0;
			done_q <= 1'b0;
			cond_q <= MSC_STILL;
			period_q <= '0;
		end else begin
			uvPrev_q <= cmpUv;
			done_q <= 1'b0;
			if (clear) begin
				seen_q <= 1'b0;
				armed_q <= 1'b1;
				cnt_q <= '0;
			end else if (armed_q && uvRise && seen_q) begin
				// Second rise closes one electrical period
				armed_q <= 1'b0;
				done_q <= 1'b1;
				period_q <= cnt_q;
				cond_q <= fwdSeen ? MSC_FWD : MSC_RVS;
			end else if (armed_q && uvRise) begin
				seen_q <= 1'b1;
				cnt_q <= '0;
			end else if (armed_q && quiet) begin
				// No toggling long enough: stationary
				armed_q <= 1'b0;
				done_q <= 1'b1;
				cond_q <= MSC_STILL;
			end else if (armed_q) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end
	dir_rvs_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		armed_q && !clear && seen_q && uvRise && cmpUw
		|=> done_q && cond_q == MSC_RVS)
		else $error("leading UW not reported as reverse");
endmodule

/* File: tb/msc_motor_model.sv */
// Behavioural coasting motor: drives the two phase comparators.
// Assumes the bench picks still, forward or reverse spin.
`timescale 1ns/100ps
module msc_motor_model #(
	parameter int STEP = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [1:0] spinMode,
	output logic cmpUv,
	output logic cmpUw
);
	// ------------------------------------------------------------
	// Sector timing
	// ------------------------------------------------------------
	logic [7:0] tick_q; // Cycles spent in the current sector
	logic [2:0] step_q; // Electrical sector, 60 degrees each
	wire spinning = (spinMode != 2'h0); // Still rotor gives no edges
	// Advance one sector every STEP cycles while the rotor turns
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 8'h00;
			step_q <= 3'h0;
		end else if (spinning && tick_q == 8'(STEP - 1)) begin
			tick_q <= 8'h00;
			step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
		end else if (spinning) begin
			tick_q <= tick_q + 8'h01;
		end
	end
	// ------------------------------------------------------------
	// Comparators: UW one sector behind UV forward, ahead reverse
	// ------------------------------------------------------------
	assign cmpUv = spinning && (step_q < 3'h3);
	assign cmpUw = (spinMode == 2'h1) ? (step_q >= 3'h1 && step_q <= 3'h3) :
		(spinMode == 2'h2) ? (step_q == 3'h5 || step_q <= 3'h1) : 1'b0;
endmodule

/* File: tb/msc_start_select_test.sv */
// Self-checking bench for the motor start-path selector.
// Assumes shortened stillness and reverse speed bases in the DUT.
`timescale 1ns/100ps
module msc_start_select_test;
	import msc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic restart = 1'b0;
	logic senseDone = 1'b0;
	logic alignDone = 1'b0;
	logic zeroSpeed = 1'b0;
	logic handoffReached = 1'b0;
	logic brakeCurrentLow = 1'b0;
	msc_cond_e spinMode = MSC_STILL; // What the motor really does
	logic cmpUv, cmpUw, coast, posSense, alignDrv, brake, rvsDrv, accel;
	logic closed;
	logic [31:0] rdData;
	logic [17:0] bemfConst;
	msc_path_e path;
	msc_cond_e motorCond;
	int errTotal = 0;
	int totalChecks = 0;
	int cycles = 0;
	always #2 clk_sys = ~clk_sys; // 250 MHz
	msc_start_select #(.STILL_BASE_CYC(40), .RVS_BASE_CYC(10)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData_q(rdData), .restart(restart), .cmpUv(cmpUv),
		.cmpUw(cmpUw), .senseDone(senseDone), .alignDone(alignDone),
		.zeroSpeed(zeroSpeed), .handoffReached(handoffReached),
		.brakeCurrentLow(brakeCurrentLow), .path_q(path),
		.motorCond_q(motorCond), .coast_q(coast), .posSense_q(posSense),
		.alignDrive_q(alignDrv), .lowSideBrake_q(brake),
		.reverseDrive_q(rvsDrv), .accelDrive_q(accel),
		.closedLoop_q(closed), .bemfConstant_q(bemfConst));
	msc_motor_model #(.STEP(4)) u_motor (.clk_sys(clk_sys), .rst_n(rst_n),
		.spinMode(spinMode), .cmpUv(cmpUv), .cmpUw(cmpUw));
	// ------------------------------------------------------------
	// Closing report and hang guard
	// ------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d errors %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Whole run needs some 3600 cycles; far beyond means a hang
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			errTotal++;
			$display("ERROR %0t: run timed out", $time);
			stop_test();
		end
	end
	// ------------------------------------------------------------
	// Compare tasks
	// ------------------------------------------------------------
	task automatic chkVal(input logic [31:0] got, exp, input string what);
		totalChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR %0t: %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	// Drive commands are one-hot and must follow the path
	task automatic chkPath(input msc_path_e p);
		logic [6:0] exp;
		case (p)
			MSC_POS_SENSE: exp = 7'h20;
			MSC_ALIGN: exp = 7'h10;
			MSC_BRAKE: exp = 7'h08;
			MSC_RVS_DRIVE: exp = 7'h04;
			MSC_ACCEL: exp = 7'h02;
			MSC_CLOSED: exp = 7'h01;
			default: exp = 7'h40; // Coasting while idle or detecting
		endcase
		chkVal({28'h0, path}, {28'h0, p}, "path");
		chkVal({25'h0, coast, posSense, alignDrv, brake, rvsDrv, accel,
			closed}, {25'h0, exp}, "drive");
	endtask
	task automatic chkCond(input msc_cond_e c);
		chkVal({30'h0, motorCond}, {30'h0, c}, "condition");
	endtask
	// ------------------------------------------------------------
	// Register port and sequencing helpers
	// ------------------------------------------------------------
	task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic regRead(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = rdData;
	endtask
	task automatic waitPath(input msc_path_e p, input int bound);
		int n;
		n = 0;
		#1;
		while (path !== p && n < bound) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chkPath(p);
	endtask
	// Configure, set the rotor going, restart and await the path
	task automatic attempt(input logic [11:0] cfg, input logic [5:0] thr,
		input msc_cond_e spin, input msc_path_e p);
		regWrite(MSC_REG_CFG, {20'h0, cfg});
		regWrite(MSC_REG_THR, {26'h0, thr});
		spinMode <= spin;
		regWrite(MSC_REG_CTRL, 32'h1);
		waitPath(p, 300);
	endtask
	// Engine reports done; answer exactly one edge later
	task automatic toClosed(input msc_path_e from);
		@(posedge clk_sys);
		senseDone <= (from == MSC_POS_SENSE);
		alignDone <= (from == MSC_ALIGN);
		zeroSpeed <= (from == MSC_RVS_DRIVE);
		@(posedge clk_sys);
		{senseDone, alignDone, zeroSpeed} <= 3'h0;
		handoffReached <= 1'b1;
		#1 chkPath(MSC_ACCEL);
		@(posedge clk_sys);
		handoffReached <= 1'b0;
		#1 chkPath(MSC_CLOSED);
	endtask
	// Path must sit in detection, never committing to a drive
	task automatic holdDetect(input int n);
		waitPath(MSC_DETECT, 20);
		repeat (n) begin
			@(posedge clk_sys);
			#1 chkPath(MSC_DETECT);
		end
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic regScenario();
		logic [31:0] d;
		logic [6:0] codes [5];
		logic [17:0] exp;
		codes = '{7'h00, 7'h01, 7'h7F, 7'h28, 7'h5C};
		regRead(MSC_REG_CFG, d);
		chkVal(d, 32'h005, "cfg reset");
		@(posedge clk_sys);
		#1 chkVal(rdData, 32'h0, "data after read");
		regRead(MSC_REG_THR, d);
		chkVal(d, 32'h0, "thr reset");
		regRead(4'hF, d);
		chkVal(d, 32'h0, "unmapped");
		regWrite(MSC_REG_KVAL, 32'hFFFFFFFF);
		regRead(MSC_REG_KVAL, d);
		chkVal(d, 32'h0, "read-only constant");
		foreach (codes[i]) begin
			exp = (18'(codes[i][3:0]) << codes[i][6:4]) * 18'd92;
			regWrite(MSC_REG_BEMF, {25'h0, codes[i]});
			regRead(MSC_REG_KVAL, d);
			chkVal(d, {14'h0, exp}, "constant");
			chkVal({14'h0, bemfConst}, {14'h0, exp}, "constant port");
		end
	endtask
	// Still rotor: align-and-go, then position sensing
	task automatic stillScenario();
		attempt(12'h005, 6'h00, MSC_STILL, MSC_ALIGN);
		chkCond(MSC_STILL);
		toClosed(MSC_ALIGN);
		attempt(12'h305, 6'h00, MSC_STILL, MSC_POS_SENSE);
		toClosed(MSC_POS_SENSE);
	endtask
	// Forward rotor: resync straight to closed loop, else as still
	task automatic forwardScenario();
		logic [31:0] d;
		attempt(12'h005, 6'h00, MSC_FWD, MSC_CLOSED);
		chkCond(MSC_FWD);
		regRead(MSC_REG_STAT, d);
		chkVal(d, {26'h0, MSC_FWD, MSC_CLOSED}, "status");
		attempt(12'h001, 6'h00, MSC_FWD, MSC_ALIGN);
		toClosed(MSC_ALIGN);
		// Detection off: a spinning rotor still counts as stationary
		attempt(12'h000, 6'h00, MSC_FWD, MSC_ALIGN);
		chkCond(MSC_STILL);
		toClosed(MSC_ALIGN);
	endtask
	// Reverse rotor: drive through zero, brake, wait or coast
	task automatic reverseScenario();
		attempt(12'h003, 6'h00, MSC_RVS, MSC_RVS_DRIVE);
		chkCond(MSC_RVS);
		toClosed(MSC_RVS_DRIVE);
		// Short brake keeps returned energy small
		attempt(12'h011, 6'h00, MSC_RVS, MSC_BRAKE);
		spinMode <= MSC_STILL;
		brakeCurrentLow <= 1'b1;
		repeat (2400) @(posedge clk_sys);
		#1 chkPath(MSC_BRAKE);
		waitPath(MSC_ALIGN, 200);
		brakeCurrentLow <= 1'b0;
		toClosed(MSC_ALIGN);
		// Too fast for a reverse drive: period 24 below 80
		regWrite(MSC_REG_CFG, 32'h003);
		regWrite(MSC_REG_THR, 32'h30);
		spinMode <= MSC_RVS;
		regWrite(MSC_REG_CTRL, 32'h1);
		holdDetect(300);
		spinMode <= MSC_STILL;
		waitPath(MSC_ALIGN, 200);
		toClosed(MSC_ALIGN);
		// No reverse drive and no brake: wait, via the restart pin
		regWrite(MSC_REG_CFG, 32'h001);
		regWrite(MSC_REG_THR, 32'h0);
		spinMode <= MSC_RVS;
		restart <= 1'b1;
		@(posedge clk_sys);
		restart <= 1'b0;
		holdDetect(300);
		spinMode <= MSC_STILL;
		waitPath(MSC_ALIGN, 200);
		chkCond(MSC_STILL);
		toClosed(MSC_ALIGN);
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		regScenario();
		stillScenario();
		forwardScenario();
		reverseScenario();
		stop_test();
	end
endmodule
